// *** design/gdo_port.sv ***
// 24-pin general-purpose port: direction, output latch, initial values, input levels
// assumes register requests and alternate-function controls come from logic on clk
//
// What this block does
// - direction word: C pins 23..16, B 15..8, A 7..0
// - direction bit one makes pin output
// - resets copy initial direction, default 000142CC
// - latch bit one drives output pin high
// - resets copy initial latch, default zero
// - reduced build: C5, B0 not controllable
// - extended build: also C6, B5 locked
// - input register reads live pin levels
// - input register takes any value, no default
// - alternate function overrides direction and latch
`timescale 1ns/100ps
module gdo_port #(
    parameter gdo_pkg::gdo_variant_t VARIANT = gdo_pkg::gdo_var_full,
    parameter int PINS = gdo_pkg::PIN_COUNT
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic soft_rst,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [gdo_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [gdo_pkg::WORD_W-1:0] reg_wdata,
    output logic [gdo_pkg::WORD_W-1:0] reg_rdata,
    output logic reg_rvalid,
    output logic reg_err,
    output logic reg_busy,
    input wire logic [PINS-1:0] alt_en,
    input wire logic [PINS-1:0] alt_out,
    input wire logic [PINS-1:0] alt_dir,
    input wire logic [PINS-1:0] pin_in,
    output logic [PINS-1:0] pin_out,
    output logic [PINS-1:0] pin_oe_n
);

    localparam logic [23:0] KEEP = gdo_pkg::gdo_keep_mask(VARIANT);
    localparam logic [7:0] UPPER_ZERO = 8'h00;

    gdo_pkg::gdo_state_t state_q;
    gdo_pkg::gdo_state_t state_d;

    logic [PINS-1:0] dir_q;
    logic [PINS-1:0] dir_d;
    logic [PINS-1:0] dir_init_q;
    logic [PINS-1:0] dir_init_d;
    logic [PINS-1:0] out_q;
    logic [PINS-1:0] out_d;
    logic [PINS-1:0] out_init_q;
    logic [PINS-1:0] out_init_d;
    logic [PINS-1:0] pin_sync;
    logic [gdo_pkg::WORD_W-1:0] rdata_q;
    logic [gdo_pkg::WORD_W-1:0] rdata_d;
    logic rvalid_q;
    logic err_q;

    // address decode
    wire running_w = (state_q == gdo_pkg::gdo_st_run);
    wire hit_dir_w = (reg_addr == gdo_pkg::REG_DIR);
    wire hit_dir_init_w = (reg_addr == gdo_pkg::REG_DIR_INIT);
    wire hit_out_w = (reg_addr == gdo_pkg::REG_OUT);
    wire hit_out_init_w = (reg_addr == gdo_pkg::REG_OUT_INIT);
    wire hit_in_w = (reg_addr == gdo_pkg::REG_IN);
    wire hit_any_w = hit_dir_w | hit_dir_init_w | hit_out_w | hit_out_init_w | hit_in_w;
    // requests during the reload window are dropped, reg_busy tells software
    wire wr_ok_w = reg_wr_en & running_w & ~soft_rst;
    wire rd_ok_w = reg_rd_en & running_w;
    wire [PINS-1:0] wdata_w = reg_wdata[PINS-1:0];
    wire loading_w = (state_q == gdo_pkg::gdo_st_load);

    // state machine: boot after hard reset, load copies the initial values
    always_comb begin
        state_d = state_q;
        case (state_q)
            gdo_pkg::gdo_st_boot: state_d = gdo_pkg::gdo_st_load;
            gdo_pkg::gdo_st_load: state_d = gdo_pkg::gdo_st_run;
            gdo_pkg::gdo_st_run: state_d = soft_rst ? gdo_pkg::gdo_st_load : gdo_pkg::gdo_st_run;
            default: state_d = gdo_pkg::gdo_st_boot;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q <= gdo_pkg::gdo_st_boot;
        end else begin
            state_q <= state_d;
        end
    end

    // reserved pins of the build are forced to input with a low latch
    assign dir_d = loading_w ? (dir_init_q & KEEP[PINS-1:0])
                 : (wr_ok_w && hit_dir_w) ? (wdata_w & KEEP[PINS-1:0]) : dir_q;
    assign out_d = loading_w ? (out_init_q & KEEP[PINS-1:0])
                 : (wr_ok_w && hit_out_w) ? (wdata_w & KEEP[PINS-1:0]) : out_q;
    assign dir_init_d = (wr_ok_w && hit_dir_init_w) ? wdata_w : dir_init_q;
    assign out_init_d = (wr_ok_w && hit_out_init_w) ? wdata_w : out_init_q;

    // live registers are reloaded in the load state, so reset only parks them
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dir_q <= '0;
            out_q <= '0;
        end else begin
            dir_q <= dir_d;
            out_q <= out_d;
        end
    end

    // initial-value registers stand in for non-volatile storage: only power-on resets them
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dir_init_q <= gdo_pkg::DIR_INIT_RST;
            out_init_q <= gdo_pkg::OUT_INIT_RST;
        end else begin
            dir_init_q <= dir_init_d;
            out_init_q <= out_init_d;
        end
    end

    gdo_pin_sync #(
        .WIDTH(PINS)
    ) u_sync (
        .clk(clk),
        .async_in(pin_in),
        .sync_out(pin_sync)
    );

    // read mux; the input word is pure observation, any value is legal
    wire [PINS-1:0] rd_sel_w = hit_dir_w ? dir_q
                             : hit_dir_init_w ? dir_init_q
                             : hit_out_w ? out_q
                             : hit_out_init_w ? out_init_q
                             : hit_in_w ? pin_sync : '0;
    assign rdata_d = rd_ok_w ? {UPPER_ZERO, rd_sel_w} : rdata_q;
    // writing the input word or an unknown number is flagged
    wire rd_bad_w = rd_ok_w & ~hit_any_w;
    wire wr_bad_w = wr_ok_w & (~hit_any_w | hit_in_w);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdata_q <= gdo_pkg::RDATA_RST;
            rvalid_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            rvalid_q <= rd_ok_w;
            err_q <= rd_bad_w | wr_bad_w;
        end
    end

    assign reg_rdata = rdata_q;
    assign reg_rvalid = rvalid_q;
    assign reg_err = err_q;
    assign reg_busy = ~running_w;

    gdo_pin_drive #(
        .WIDTH(PINS)
    ) u_drive (
        .dir(dir_q),
        .latch(out_q),
        .alt_en(alt_en),
        .alt_out(alt_out),
        .alt_dir(alt_dir),
        .pin_out(pin_out),
        .pin_oe_n(pin_oe_n)
    );

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_soft_req;
        soft_rst && running_w;
    endsequence

    sequence s_reload;
        loading_w ##1 running_w;
    endsequence

    reload_seq_a: assert property (s_soft_req |=> s_reload)
        else $error("soft reset did not pass through reload");

    dir_reload_a: assert property (loading_w |=> dir_q == ($past(dir_init_q) & KEEP[PINS-1:0]))
        else $error("direction not loaded from initial value");

    out_reload_a: assert property (loading_w |=> out_q == ($past(out_init_q) & KEEP[PINS-1:0]))
        else $error("latch not loaded from initial value");

    dir_layout_a: assert property (rd_ok_w && hit_dir_w |=> reg_rvalid && reg_rdata == {UPPER_ZERO, $past(dir_q)})
        else $error("direction word read back wrong");

    dir_drive_a: assert property (running_w |-> (~pin_oe_n & ~alt_en) == (dir_q & ~alt_en))
        else $error("pin drive does not follow direction");

    out_high_a: assert property ((~alt_en & dir_q & pin_out) == (~alt_en & dir_q & out_q))
        else $error("driven pin level does not follow latch");

    reduced_lock_a: assert property (((dir_q | out_q) & gdo_pkg::REDUCED_MASK[PINS-1:0] & ~KEEP[PINS-1:0]) == '0)
        else $error("reserved pin became controllable");

    extended_lock_a: assert property (wr_ok_w && hit_dir_w |=> (dir_q & ~KEEP[PINS-1:0]) == '0)
        else $error("locked pin direction was written");

    input_read_a: assert property (rd_ok_w && hit_in_w |=> reg_rdata == {UPPER_ZERO, $past(pin_sync)})
        else $error("input word does not match pin levels");

    input_any_a: assert property (rd_ok_w && hit_in_w |=> !reg_err && reg_rvalid)
        else $error("input word read was refused");

    alt_over_a: assert property ((alt_en & pin_out) == (alt_en & alt_out) && (alt_en & ~pin_oe_n) == (alt_en & alt_dir))
        else $error("alternate function did not take the pin");

    write_next_a: assert property (wr_ok_w && hit_out_w |=> out_q == ($past(wdata_w) & KEEP[PINS-1:0]))
        else $error("latch write not visible next cycle");

    // boot, register answers and locked bits
    sequence s_boot_entry;
        state_q == gdo_pkg::gdo_st_boot;
    endsequence

    sequence s_dir_write;
        wr_ok_w && hit_dir_w;
    endsequence

    sequence s_in_write;
        wr_ok_w && hit_in_w;
    endsequence

    sequence s_answer;
        reg_rvalid && !reg_err;
    endsequence

    boot_path_a: assert property (s_boot_entry |=> s_reload)
        else $error("boot did not pass through reload");

    // direction writes: masked, next cycle, nothing but a write or a reload moves it
    dir_write_a: assert property (s_dir_write |=> dir_q == ($past(wdata_w) & KEEP[PINS-1:0]))
        else $error("direction write not visible next cycle");

    dir_pin_a: assert property (s_dir_write |=>
        (pin_oe_n | alt_en) == ~($past(wdata_w) & KEEP[PINS-1:0] & ~alt_en))
        else $error("pin drive does not follow written direction");

    dir_hold_a: assert property (running_w && !soft_rst && !(wr_ok_w && hit_dir_w) |=> $stable(dir_q))
        else $error("direction changed without a write");

    out_hold_a: assert property (running_w && !soft_rst && !(wr_ok_w && hit_out_w) |=> $stable(out_q))
        else $error("latch changed without a write");

    // reserved pins stay input with a low latch
    out_lock_a: assert property (wr_ok_w && hit_out_w |=> (out_q & ~KEEP[PINS-1:0]) == '0)
        else $error("locked pin latch was written");

    free_pins_a: assert property ((~pin_oe_n & ~alt_en & ~KEEP[PINS-1:0]) == '0)
        else $error("reserved pin driven without alternate function");

    dir_zero_rd_a: assert property (rd_ok_w && hit_dir_w |=> (reg_rdata[PINS-1:0] & ~KEEP[PINS-1:0]) == '0)
        else $error("reserved direction bit read back set");

    // initial values change only by their own writes
    dir_init_wr_a: assert property (wr_ok_w && hit_dir_init_w |=> dir_init_q == $past(wdata_w))
        else $error("initial direction write lost");

    out_init_wr_a: assert property (wr_ok_w && hit_out_init_w |=> out_init_q == $past(wdata_w))
        else $error("initial latch write lost");

    init_keep_a: assert property (s_soft_req |=> $stable(dir_init_q) && $stable(out_init_q))
        else $error("soft reset disturbed initial values");

    busy_init_a: assert property (!running_w |=> $stable(dir_init_q) && $stable(out_init_q))
        else $error("initial value changed during reload");

    // register port answers
    in_write_err_a: assert property (s_in_write |=> reg_err)
        else $error("write to input word not flagged");

    in_write_safe_a: assert property (s_in_write |=> $stable(dir_q) && $stable(out_q))
        else $error("write to input word changed a register");

    mapped_read_a: assert property (rd_ok_w && hit_any_w && !wr_ok_w |=> s_answer)
        else $error("mapped read not answered cleanly");

    rvalid_pulse_a: assert property (!rd_ok_w |=> !reg_rvalid)
        else $error("read answer without a read");

    rdata_hold_a: assert property (!rd_ok_w |=> $stable(reg_rdata))
        else $error("read data moved without a read");

    upper_zero_a: assert property (reg_rdata[gdo_pkg::WORD_W-1:PINS] == '0)
        else $error("unused upper read bits not zero");

    out_layout_a: assert property (rd_ok_w && hit_out_w |=> reg_rdata == {UPPER_ZERO, $past(out_q)})
        else $error("latch word read back wrong");

    init_dir_a: assert property (rd_ok_w && hit_dir_init_w |=> reg_rdata == {UPPER_ZERO, $past(dir_init_q)})
        else $error("initial direction read back wrong");

    init_out_a: assert property (rd_ok_w && hit_out_init_w |=> reg_rdata == {UPPER_ZERO, $past(out_init_q)})
        else $error("initial latch read back wrong");

    in_delay_a: assert property (rd_ok_w && hit_in_w |=> reg_rdata[PINS-1:0] == $past(pin_in, 3))
        else $error("input word not two stages behind the pins");

endmodule

// *** common/gdo_pkg.sv ***
// constants, types and helpers shared by the general-purpose pin port
// assumes one clock domain and a synchronous active-high reset
package gdo_pkg;

    localparam int PIN_COUNT = 24;
    localparam int WORD_W = 32;
    localparam int ADDR_W = 8;

    // register numbers, as software addresses them
    localparam logic [7:0] REG_DIR = 8'h16;
    localparam logic [7:0] REG_DIR_INIT = 8'h17;
    localparam logic [7:0] REG_OUT = 8'h18;
    localparam logic [7:0] REG_OUT_INIT = 8'h19;
    localparam logic [7:0] REG_IN = 8'h1a;

    // power-on contents of the initial-value registers and of the read data register
    localparam logic [23:0] DIR_INIT_RST = 24'h01_42cc;
    localparam logic [23:0] OUT_INIT_RST = 24'h00_0000;
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;

    // field positions of the pins that variants take away
    localparam int GROUP_B_PIN0 = 8;
    localparam int GROUP_B_PIN5 = 13;
    localparam int GROUP_C_PIN5 = 21;
    localparam int GROUP_C_PIN6 = 22;

    localparam logic [23:0] ALL_PINS = 24'hff_ffff;
    localparam logic [23:0] REDUCED_MASK = 24'h20_0100;
    localparam logic [23:0] EXTENDED_MASK = 24'h60_2100;

    typedef enum logic [1:0] {
        gdo_var_full = 2'b00,
        gdo_var_reduced = 2'b01,
        gdo_var_extended = 2'b10
    } gdo_variant_t;

    typedef enum logic [1:0] {
        gdo_st_boot = 2'b00,
        gdo_st_load = 2'b01,
        gdo_st_run = 2'b11
    } gdo_state_t;

    // bits that software may steer on a given build
    function automatic logic [23:0] gdo_keep_mask(input gdo_variant_t v);
        logic [23:0] m;
        m = ALL_PINS;
        case (v)
            gdo_var_reduced: m = ~REDUCED_MASK;
            gdo_var_extended: m = ~EXTENDED_MASK;
            default: m = ALL_PINS;
        endcase
        return m;
    endfunction

endpackage

// *** design/gdo_pin_sync.sv ***
// two-stage synchroniser for the pin levels
// assumes pins are asynchronous to clk; data only, so no reset
`timescale 1ns/100ps
module gdo_pin_sync #(
    parameter int WIDTH = 24
) (
    input wire logic clk,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // first stage feeds only the second stage
    always_ff @(posedge clk) begin
        meta_q <= async_in;
        sync_q <= meta_q;
    end

    assign sync_out = sync_q;

endmodule

// *** design/gdo_pin_drive.sv ***
// per-pin output mux: alternate function, direction and latch
// assumes all inputs come from flops on the same clock
`timescale 1ns/100ps
module gdo_pin_drive #(
    parameter int WIDTH = 24
) (
    input wire logic [WIDTH-1:0] dir,
    input wire logic [WIDTH-1:0] latch,
    input wire logic [WIDTH-1:0] alt_en,
    input wire logic [WIDTH-1:0] alt_out,
    input wire logic [WIDTH-1:0] alt_dir,
    output logic [WIDTH-1:0] pin_out,
    output logic [WIDTH-1:0] pin_oe_n
);

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_pin
            wire drive_w = alt_en[i] ? alt_dir[i] : dir[i];
            // undriven pins still present the latch, or alt_out when alt_en is set, so nothing floats internally
            assign pin_out[i] = alt_en[i] ? alt_out[i] : latch[i];
            assign pin_oe_n[i] = ~drive_w;
        end
    endgenerate

endmodule

// *** sim/gdo_pin_model.sv ***
// far side of the port: pins with external drivers attached
// assumes ext_val comes from the bench; the port wins where it drives
`timescale 1ns/100ps
module gdo_pin_model (
    input wire logic [23:0] pin_out,
    input wire logic [23:0] pin_oe_n,
    input wire logic [23:0] ext_val,
    output logic [23:0] pin_in
);
    // oe_n low means the port drives; otherwise the outside level shows
    assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_val);
endmodule

// *** sim/testbench.sv ***
// register-level tests of the pin port on all three build variants
// assumes the variant instances share every input with dut
`timescale 1ns/100ps
module testbench;
    logic clk, sys_rst, soft_rst, reg_wr_en, reg_rd_en, reg_rvalid, reg_err, reg_busy, e;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rd_r, rd_x, d;
    logic [23:0] alt_en, alt_out, alt_dir, pin_in, pin_out, pin_oe_n, ext_val, po_r, oe_r, po_x, oe_x;
    int errors, n_compared;

    gdo_port dut (.*);
    gdo_port #(.VARIANT(gdo_pkg::gdo_var_reduced)) dut_r (.*, .reg_rdata(rd_r), .reg_rvalid(), .reg_err(),
        .reg_busy(), .pin_out(po_r), .pin_oe_n(oe_r));
    gdo_port #(.VARIANT(gdo_pkg::gdo_var_extended)) dut_x (.*, .reg_rdata(rd_x), .reg_rvalid(), .reg_err(),
        .reg_busy(), .pin_out(po_x), .pin_oe_n(oe_x));
    gdo_pin_model pins (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_val(ext_val), .pin_in(pin_in));

    initial begin
        clk = 0;
        forever #4 clk = ~clk;
    end

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task end_of_test;
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task wait_idle;
        for (int i = 0; i < 8 && reg_busy !== 1'b0; i++) @(negedge clk);
        chk("busy", reg_busy, 0);
    endtask

    task do_rst;
        @(negedge clk);
        sys_rst = 1;
        repeat (2) @(negedge clk);
        sys_rst = 0;
        wait_idle();
    endtask

    task wr(input logic [7:0] a, input logic [31:0] v);
        @(negedge clk);
        reg_wr_en = 1;
        reg_addr = a;
        reg_wdata = v;
        @(negedge clk);
        reg_wr_en = 0;
        e = reg_err;
    endtask

    task rd(input logic [7:0] a, output logic [31:0] v);
        @(negedge clk);
        reg_rd_en = 1;
        reg_addr = a;
        @(negedge clk);
        reg_rd_en = 0;
        v = reg_rdata;
        e = reg_err;
        chk("rvalid", reg_rvalid, 1);
    endtask

    task boot_chk;
        rd(gdo_pkg::REG_DIR, d);
        chk("dir", d, 32'h0001_42cc);
        rd(gdo_pkg::REG_OUT, d);
        chk("out", d, 32'h0000_0000);
        chk("oe_n", pin_oe_n, 32'h00fe_bd33);
        rd(gdo_pkg::REG_DIR_INIT, d);
        chk("dir_init", d, 32'h0001_42cc);
        rd(gdo_pkg::REG_OUT_INIT, d);
        chk("out_init", d, 32'h0000_0000);
    endtask

    initial begin
        {soft_rst, reg_wr_en, reg_rd_en, reg_addr, reg_wdata} = '0;
        sys_rst = 1;
        {alt_en, alt_out, alt_dir} = '0;
        ext_val = 24'h3c_c33c;
        errors = 0;
        n_compared = 0;
        do_rst();
        boot_chk();
        // every pin asked for output and high; variants keep their reserved pins
        wr(gdo_pkg::REG_DIR, 32'hffff_ffff);
        chk("wr_err", e, 0);
        wr(gdo_pkg::REG_OUT, 32'hffff_ffff);
        chk("oe_n", pin_oe_n, 32'h0000_0000);
        chk("pins", pin_out, 32'h00ff_ffff);
        chk("oe_r", oe_r, {8'h00, gdo_pkg::REDUCED_MASK});
        chk("po_r", {8'h00, po_r | oe_r}, 32'h00ff_ffff);
        chk("oe_x", oe_x, {8'h00, gdo_pkg::EXTENDED_MASK});
        chk("po_x", {8'h00, po_x | oe_x}, 32'h00ff_ffff);
        rd(gdo_pkg::REG_DIR, d);
        chk("dir", d, 32'h00ff_ffff);
        chk("dir_r", rd_r, {8'h00, ~gdo_pkg::REDUCED_MASK});
        chk("dir_x", rd_x, {8'h00, ~gdo_pkg::EXTENDED_MASK});
        rd(gdo_pkg::REG_OUT, d);
        chk("out_r", rd_r, {8'h00, ~gdo_pkg::REDUCED_MASK});
        // mixed directions: outputs show the latch, inputs the outside level
        wr(gdo_pkg::REG_DIR, 32'h00ff_00ff);
        wr(gdo_pkg::REG_OUT, 32'h00a5_005a);
        chk("oe_n", pin_oe_n, 32'h0000_ff00);
        repeat (3) @(negedge clk);
        rd(gdo_pkg::REG_IN, d);
        chk("in", d, 32'h00a5_c35a);
        wr(gdo_pkg::REG_IN, 32'h0000_0000);
        chk("in_wr_err", e, 1);
        rd(gdo_pkg::REG_IN, d);
        chk("in", d, 32'h00a5_c35a);
        wr(gdo_pkg::REG_DIR, 32'h0000_0000);
        for (int i = 0; i < 2; i++) begin
            ext_val = {24{i[0]}};
            repeat (3) @(negedge clk);
            rd(gdo_pkg::REG_IN, d);
            chk("in_edge", d, {8'h00, ext_val});
        end
        rd(8'h20, d);
        chk("unmapped_err", e, 1);
        wr(8'h20, 32'h0000_0001);
        chk("unmapped_wr_err", e, 1);
        // alternate function owns pins 0 and 1 whatever dir says
        wr(gdo_pkg::REG_DIR, 32'h0000_0002);
        alt_en = 24'h00_0003;
        alt_dir = 24'h00_0001;
        alt_out = 24'h00_0001;
        @(negedge clk);
        chk("alt_oe", pin_oe_n, 32'h00ff_fffe);
        chk("alt_out", pin_out[0], 1);
        alt_en = 24'h00_0000;
        @(negedge clk);
        chk("oe_n", pin_oe_n, 32'h00ff_fffd);
        // soft reset reloads live registers, keeps the initial ones
        wr(gdo_pkg::REG_DIR_INIT, 32'h0012_3456);
        wr(gdo_pkg::REG_OUT_INIT, 32'h0000_00ff);
        // writes in the soft reset cycle and during reload must be dropped
        @(negedge clk);
        soft_rst = 1;
        reg_wr_en = 1;
        reg_addr = gdo_pkg::REG_DIR_INIT;
        reg_wdata = 32'h0000_0000;
        @(negedge clk);
        soft_rst = 0;
        reg_addr = gdo_pkg::REG_OUT;
        chk("busy_reload", reg_busy, 1);
        @(negedge clk);
        reg_wr_en = 0;
        wait_idle();
        rd(gdo_pkg::REG_DIR, d);
        chk("dir", d, 32'h0012_3456);
        rd(gdo_pkg::REG_OUT, d);
        chk("out", d, 32'h0000_00ff);
        rd(gdo_pkg::REG_DIR_INIT, d);
        chk("dir_init", d, 32'h0012_3456);
        rd(gdo_pkg::REG_OUT_INIT, d);
        chk("out_init", d, 32'h0000_00ff);
        do_rst();
        boot_chk();
        end_of_test();
    end

    // tests need under a hundred cycles
    initial begin
        #16000;
        errors++;
        end_of_test();
    end
endmodule
